// [pic_cfg.svh]
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH

// ==========================================================================
// Register indices on the special-purpose data port
`define PIC_ADDR_HALL_EDGE 5'h00
`define PIC_ADDR_PIN_EDGE 5'h01
`define PIC_ADDR_GLOBAL_AND_LEVELS_1_3 5'h02
`define PIC_ADDR_LEVELS_4_7_CONTROL 5'h03
`define PIC_ADDR_LEVELS_8_11_CONTROL 5'h04
`define PIC_ADDR_LEVELS_12_15_CONTROL 5'h05
`define PIC_ADDR_HALL_GROUP_IRQ 5'h06
`define PIC_ADDR_MAP0 5'h0e
`define PIC_NUM_MFI 8
`define PIC_NUM_MAP 8

// ==========================================================================
// Reset values and field layout
`define PIC_REG_RST 8'h00
`define PIC_HALL_EDGE_MASK 8'h7f
`define PIC_PIN_EDGE_MASK 8'h0f
`define PIC_HSEL_BIT 6
`define PIC_PREEMPT_LSB 2
`define PIC_GIE_BIT 0
`define PIC_FLAG_LSB 4
`define PIC_LOW_LEVELS 3
// Implemented bits of the eight multi-function registers, group 7 down to 0
`define PIC_MFI_IMPL 64'hff33_3333_3333_ff77
`define PIC_MAP_MASK 64'h0fff_ffff_ffff_ffff

`endif

// [pic_controller.sv]
// Contract
// R1: Hall A/B/C grouped as number 1
// R2: PWM period/duty0-2 number 3; duty3 number 4
// R3: A/D autoscan and normal EOC number 8
// R4: Comparator 2, overflow 5, compare 6, limit 7
// R5: Edge pin 12, filtered pin 13
// R6: Timers 9,10,11,14; serial/misc group 15
// R7: Flagless sources use level enable and flag
// R8: Hall edge select off/rise/fall/both
// R9: External pin edge select off/rise/fall/both
// R10: Preempt control field stored, read/write
// R11: Global enable gates all servicing
// R12: Levels 1-3 flags and enables layout
// R13: Levels 4-7 flags and enables layout
// R14: Levels 8-15 flags and enables layout
// R15: Flags read pending, software writable; enables
// R16: Reset to zero, unimplemented bits read zero
// R17: Accepted call suspends program until return
// R18: Unassigned number sets only source flag
// R19: Number on several levels calls each
// R20: Fifteen levels, vector four times level
// R21: Software maps levels, clears flags once
// R22: Level flag set when number signals
// R23: Request needs global, level enable, flag
`timescale 1ns/1ps
`default_nettype none
`include "pic_cfg.svh"

module pic_controller (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire pic_pkg::pic_addr_t i_reg_addr,
  input wire logic i_reg_wr,
  input wire pic_pkg::pic_byte_t i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Pins
  input wire logic [2:0] i_hall_pin,
  input wire logic i_ext_irq_pin,
  input wire logic i_filtered_irq_pin,
  // Internal event pulses
  input wire logic i_comparator_event,
  input wire logic [3:0] i_pwm_event,
  input wire logic i_pwm_duty3_event,
  input wire logic i_capture_overflow_event,
  input wire logic i_capture_compare_event,
  input wire logic i_adc_limit_event,
  input wire logic [1:0] i_adc_eoc_event,
  input wire logic [1:0] i_timer2_event,
  input wire logic [1:0] i_timer0_event,
  input wire logic [1:0] i_timer1_event,
  input wire logic [1:0] i_timer3_event,
  input wire logic [3:0] i_serial_misc_event,
  // Processor core
  output logic o_irq_req,
  output logic [7:0] o_irq_vector,
  input wire logic i_irq_ack,
  input wire logic i_irq_return,
  output logic [1:0] o_vector_preempt_ctrl,
  output logic o_hall_source_sel
);
  import pic_pkg::*;

  // ========================================================================
  // Edge qualification
  function automatic logic edge_hit(input pic_edge_e sel, input logic rise, input logic fall);
    edge_hit = ((sel == PIC_EDGE_RISE) && rise) || ((sel == PIC_EDGE_FALL) && fall) ||
               ((sel == PIC_EDGE_BOTH) && (rise || fall));
  endfunction : edge_hit

  // ========================================================================
  // Storage
  pic_byte_t hall_edge_r;
  pic_byte_t pin_edge_r;
  logic gie_r;
  logic [15:1] lvl_en_r;
  logic [15:1] lvl_flag_r;
  pic_byte_t mfi_r [`PIC_NUM_MFI];
  pic_byte_t map_r [`PIC_NUM_MAP];
  logic [3:0] mf_prev_r [`PIC_NUM_MFI];
  logic req_r;
  pic_level_t sel_lvl_r;
  logic [7:0] vec_r;
  logic [7:0] rdata_r;

  // ========================================================================
  // Pin synchronisers; a change counts once stages two and three agree
  logic [4:0] pin_in;
  logic [4:0] pin_s1_r, pin_s2_r, pin_s3_r;
  logic [4:0] pin_stable_r;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;
  logic [4:0] pin_evt;
  pic_edge_e pin_sel [5];

  assign pin_in = {i_filtered_irq_pin, i_ext_irq_pin, i_hall_pin};
  assign pin_sel[0] = pic_edge_e'(hall_edge_r[1:0]); // [R8]
  assign pin_sel[1] = pic_edge_e'(hall_edge_r[3:2]); // [R8]
  assign pin_sel[2] = pic_edge_e'(hall_edge_r[5:4]); // [R8]
  assign pin_sel[3] = pic_edge_e'(pin_edge_r[1:0]); // [R9]
  // The filtered pin has no edge select; it is taken on rising edges
  assign pin_sel[4] = PIC_EDGE_RISE;

  genvar gp;
  generate
    for (gp = 0; gp < 5; gp++) begin : g_pin
      assign pin_rise[gp] = (pin_s2_r[gp] == pin_s3_r[gp]) && pin_s3_r[gp] && !pin_stable_r[gp];
      assign pin_fall[gp] = (pin_s2_r[gp] == pin_s3_r[gp]) && !pin_s3_r[gp] && pin_stable_r[gp];
      assign pin_evt[gp] = edge_hit(pin_sel[gp], pin_rise[gp], pin_fall[gp]); // [R8] [R9]
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
      pin_s3_r <= 5'h00;
      pin_stable_r <= 5'h00;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_stable_r <= (pin_s2_r == pin_s3_r) ? pin_s3_r : pin_stable_r;
    end
  end

  // ========================================================================
  // Multi-function groups: source flags in the high nibble, enables low
  logic [3:0] mf_evt [`PIC_NUM_MFI];
  logic [3:0] mf_act [`PIC_NUM_MFI];
  logic [7:0] mf_hit;
  logic [7:0] mf_wr;
  logic [63:0] mfi_impl;

  assign mfi_impl = `PIC_MFI_IMPL;
  assign mf_evt[0] = {1'b0, pin_evt[2:0]}; // [R1]
  assign mf_evt[1] = i_pwm_event; // [R2]
  assign mf_evt[2] = {2'b00, i_adc_eoc_event}; // [R3]
  assign mf_evt[3] = {2'b00, i_timer2_event}; // [R6]
  assign mf_evt[4] = {2'b00, i_timer0_event}; // [R6]
  assign mf_evt[5] = {2'b00, i_timer1_event}; // [R6]
  assign mf_evt[6] = {2'b00, i_timer3_event}; // [R6]
  assign mf_evt[7] = i_serial_misc_event; // [R6]

  genvar gm;
  generate
    for (gm = 0; gm < `PIC_NUM_MFI; gm++) begin : g_mfi
      logic [7:0] nxt;
      assign mf_wr[gm] = i_reg_wr && (i_reg_addr == (`PIC_ADDR_HALL_GROUP_IRQ + 5'(gm)));
      assign mf_act[gm] = mfi_r[gm][7:4] & mfi_r[gm][3:0];
      // A group signals its number when any source newly has flag and enable both set
      assign mf_hit[gm] = |(mf_act[gm] & ~mf_prev_r[gm]); // [R22]
      // Hardware set wins over a software clear in the same cycle
      assign nxt = ((mf_wr[gm] ? i_reg_wdata : mfi_r[gm]) | {mf_evt[gm], 4'h0}) &
                   mfi_impl[gm*8 +: 8]; // [R15] [R16]
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          mfi_r[gm] <= `PIC_REG_RST;
          mf_prev_r[gm] <= 4'h0;
        end else begin
          mfi_r[gm] <= nxt;
          mf_prev_r[gm] <= mf_act[gm];
        end
      end
    end
  endgenerate

  // ========================================================================
  // Interrupt numbers; bit 0 stands for an unassigned level
  logic [15:0] num_vec;

  assign num_vec = {mf_hit[7], mf_hit[6], pin_evt[4], pin_evt[3], // [R5] [R6]
                    mf_hit[5], mf_hit[4], mf_hit[3], mf_hit[2], // [R3] [R6]
                    i_adc_limit_event, i_capture_compare_event, // [R4]
                    i_capture_overflow_event, i_pwm_duty3_event, // [R2] [R4]
                    mf_hit[1], i_comparator_event, mf_hit[0], 1'b0}; // [R1] [R4]

  // ========================================================================
  // Priority map and level flags
  logic [63:0] map_flat;
  logic [15:1] lvl_hit;
  logic [15:1] lvl_wr;
  logic [15:1] pend;
  logic [3:0] intc_wr;
  logic ack_take;

  assign ack_take = i_irq_ack && req_r;
  assign intc_wr[0] = i_reg_wr && (i_reg_addr == `PIC_ADDR_GLOBAL_AND_LEVELS_1_3);
  assign intc_wr[1] = i_reg_wr && (i_reg_addr == `PIC_ADDR_LEVELS_4_7_CONTROL);
  assign intc_wr[2] = i_reg_wr && (i_reg_addr == `PIC_ADDR_LEVELS_8_11_CONTROL);
  assign intc_wr[3] = i_reg_wr && (i_reg_addr == `PIC_ADDR_LEVELS_12_15_CONTROL);

  genvar gl;
  generate
    for (gl = 0; gl < `PIC_NUM_MAP; gl++) begin : g_map
      assign map_flat[gl*8 +: 8] = map_r[gl];
    end
    for (gl = 1; gl <= 15; gl++) begin : g_lvl
      localparam int REG = (gl <= `PIC_LOW_LEVELS) ? 0 : gl / 4;
      localparam int EBIT = (gl <= `PIC_LOW_LEVELS) ? gl : gl % 4;
      localparam int FBIT = (gl <= `PIC_LOW_LEVELS) ? gl + `PIC_LOW_LEVELS : gl % 4 + `PIC_FLAG_LSB;
      logic flag_nxt;
      // An unassigned level reads bit 0 and never fires; a shared number fires every level
      assign lvl_hit[gl] = num_vec[map_flat[(gl-1)*4 +: 4]]; // [R7] [R18] [R19] [R22]
      assign lvl_wr[gl] = intc_wr[REG];
      assign pend[gl] = gie_r && lvl_en_r[gl] && lvl_flag_r[gl]; // [R11] [R23]
      assign flag_nxt = (lvl_wr[gl] ? i_reg_wdata[FBIT] :
                         ((ack_take && (sel_lvl_r == 4'(gl))) ? 1'b0 : lvl_flag_r[gl])) |
                        lvl_hit[gl]; // [R12] [R13] [R14] [R15]
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          lvl_flag_r[gl] <= 1'b0;
          lvl_en_r[gl] <= 1'b0;
        end else begin
          lvl_flag_r[gl] <= flag_nxt;
          lvl_en_r[gl] <= lvl_wr[gl] ? i_reg_wdata[EBIT] : lvl_en_r[gl]; // [R15]
        end
      end
    end
  endgenerate

  // ========================================================================
  // Selection: the lowest pending level has the highest priority
  pic_level_t best;

  always_comb begin
    best = 4'h0;
    for (int l = 15; l >= 1; l--) begin
      if (pend[l]) begin
        best = 4'(l); // [R23]
      end
    end
  end

  // ========================================================================
  // Control registers and core handshake
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hall_edge_r <= `PIC_REG_RST;
      pin_edge_r <= `PIC_REG_RST;
      gie_r <= 1'b0;
    end else begin
      if (i_reg_wr && (i_reg_addr == `PIC_ADDR_HALL_EDGE)) begin
        hall_edge_r <= i_reg_wdata & `PIC_HALL_EDGE_MASK; // [R8] [R16]
      end
      if (i_reg_wr && (i_reg_addr == `PIC_ADDR_PIN_EDGE)) begin
        pin_edge_r <= i_reg_wdata & `PIC_PIN_EDGE_MASK; // [R9] [R10] [R16]
      end
      // Entry masks further calls until the core returns; a write takes precedence
      if (intc_wr[0]) begin
        gie_r <= i_reg_wdata[`PIC_GIE_BIT]; // [R11]
      end else if (ack_take) begin
        gie_r <= 1'b0; // [R17]
      end else if (i_irq_return) begin
        gie_r <= 1'b1; // [R17]
      end
    end
  end

  generate
    for (gl = 0; gl < `PIC_NUM_MAP; gl++) begin : g_mapreg
      logic [63:0] map_mask;
      assign map_mask = `PIC_MAP_MASK;
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          map_r[gl] <= `PIC_REG_RST;
        end else if (i_reg_wr && (i_reg_addr == (`PIC_ADDR_MAP0 + 5'(gl)))) begin
          map_r[gl] <= i_reg_wdata & map_mask[gl*8 +: 8]; // [R16]
        end
      end
    end
  endgenerate

  // Request and vector are registered together so the vector never runs ahead
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_r <= 1'b0;
      sel_lvl_r <= 4'h0;
      vec_r <= 8'h00;
    end else begin
      req_r <= (best != 4'h0) && !ack_take; // [R23]
      sel_lvl_r <= best;
      vec_r <= {2'b00, best, 2'b00}; // [R20]
    end
  end

  // ========================================================================
  // Read-back, one cycle after the address
  logic [7:0] rd_mux;
  logic [7:0] intc_rd [4];
  logic [4:0] map_idx, mfi_idx;

  assign intc_rd[0] = {1'b0, lvl_flag_r[3:1], lvl_en_r[3:1], gie_r}; // [R11] [R12]
  assign intc_rd[1] = {lvl_flag_r[7:4], lvl_en_r[7:4]}; // [R13]
  assign intc_rd[2] = {lvl_flag_r[11:8], lvl_en_r[11:8]}; // [R14]
  assign intc_rd[3] = {lvl_flag_r[15:12], lvl_en_r[15:12]}; // [R14]
  assign map_idx = i_reg_addr - `PIC_ADDR_MAP0;
  assign mfi_idx = i_reg_addr - `PIC_ADDR_HALL_GROUP_IRQ;
  assign rd_mux = (i_reg_addr == `PIC_ADDR_HALL_EDGE) ? hall_edge_r :
                  (i_reg_addr == `PIC_ADDR_PIN_EDGE) ? pin_edge_r :
                  (i_reg_addr < `PIC_ADDR_HALL_GROUP_IRQ) ? intc_rd[2'(i_reg_addr - `PIC_ADDR_GLOBAL_AND_LEVELS_1_3)] :
                  (i_reg_addr < `PIC_ADDR_MAP0) ? mfi_r[3'(mfi_idx)] :
                  (map_idx < 5'(`PIC_NUM_MAP)) ? map_r[3'(map_idx)] : 8'h00; // [R16]

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd_mux;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_irq_req = req_r;
  assign o_irq_vector = vec_r;
  assign o_vector_preempt_ctrl = pin_edge_r[`PIC_PREEMPT_LSB +: 2];
  assign o_hall_source_sel = hall_edge_r[`PIC_HSEL_BIT];

  // ========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_accept;
    o_irq_req && i_irq_ack && !i_reg_wr;
  endsequence
  property p_req_needs_gie;
    o_irq_req |-> $past(gie_r);
  endproperty
  a_req_needs_gie: assert property (p_req_needs_gie) else $error("request without global enable"); // [R11]
  property p_vector_shape;
    o_irq_req |-> (o_irq_vector >= 8'h04) && (o_irq_vector <= 8'h3c) && (o_irq_vector[1:0] == 2'b00);
  endproperty
  a_vector_shape: assert property (p_vector_shape) else $error("vector out of range"); // [R20]
  property p_accept_masks;
    s_accept |=> !gie_r ##1 !o_irq_req;
  endproperty
  a_accept_masks: assert property (p_accept_masks) else $error("accept did not mask"); // [R17]
  property p_top_level_first;
    (pend[1] && !ack_take) |=> o_irq_req && (o_irq_vector == 8'h04);
  endproperty
  a_top_level_first: assert property (p_top_level_first) else $error("level 1 not chosen"); // [R23]
  property p_hit_sets_flag;
    lvl_hit[2] |=> lvl_flag_r[2];
  endproperty
  a_hit_sets_flag: assert property (p_hit_sets_flag) else $error("level flag missed"); // [R22]
  property p_unassigned_quiet;
    (map_r[0][3:0] == 4'h0 && !i_reg_wr) |=> !$rose(lvl_flag_r[1]);
  endproperty
  a_unassigned_quiet: assert property (p_unassigned_quiet) else $error("unassigned level fired"); // [R18]
  property p_hall_rise;
    (pin_sel[0] == PIC_EDGE_RISE && pin_rise[0] && !i_reg_wr) |=> mfi_r[0][4];
  endproperty
  a_hall_rise: assert property (p_hall_rise) else $error("hall A flag missed"); // [R8]
  property p_ext_off;
    (pin_edge_r[1:0] == 2'b00) |-> !num_vec[12];
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("disabled pin fired"); // [R9]
  property p_hall_group_irq_reserved;
    (i_reg_addr == `PIC_ADDR_HALL_GROUP_IRQ) |=> (o_reg_rdata[7] == 1'b0) && (o_reg_rdata[3] == 1'b0);
  endproperty
  a_hall_group_irq_reserved: assert property (p_hall_group_irq_reserved) else $error("reserved bit set"); // [R16]

endmodule : pic_controller

`default_nettype wire

// [pic_core_model.sv]
`timescale 1ns/1ps
`default_nettype none

module pic_core_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Call interface
  input wire logic i_irq_req,
  input wire logic [7:0] i_irq_vector,
  input wire logic [3:0] i_ack_delay,
  output logic o_irq_ack,
  output logic o_irq_return,
  // Observation
  output logic [7:0] o_last_vector,
  output logic [7:0] o_call_count
);
  logic [3:0] cnt_r;
  logic busy_r;

  // ==========================================================
  // Accept a shown call after a chosen delay, serve, then return
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_ack <= 1'b0;
      o_irq_return <= 1'b0;
      o_last_vector <= 8'h00;
      o_call_count <= 8'h00;
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
    end else begin
      o_irq_ack <= 1'b0;
      o_irq_return <= 1'b0;
      if (o_irq_ack) begin
        o_last_vector <= i_irq_vector;
        o_call_count <= o_call_count + 8'h01;
        busy_r <= 1'b1;
        cnt_r <= 4'h0;
      end else if (busy_r) begin
        // Main flow resumes only after the service ends
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == 4'h4) begin
          o_irq_return <= 1'b1;
          busy_r <= 1'b0;
          cnt_r <= 4'h0;
        end
      end else if (i_irq_req) begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r >= i_ack_delay) begin
          o_irq_ack <= 1'b1;
        end
      end else begin
        cnt_r <= 4'h0;
      end
    end
  end
endmodule : pic_core_model

`default_nettype wire

// [pic_pkg.sv]
`default_nettype none

package pic_pkg;
  typedef logic [7:0] pic_byte_t;
  typedef logic [4:0] pic_addr_t;
  typedef logic [3:0] pic_level_t;
  typedef enum logic [1:0] {
    PIC_EDGE_OFF = 2'h0,
    PIC_EDGE_RISE = 2'h1,
    PIC_EDGE_FALL = 2'h2,
    PIC_EDGE_BOTH = 2'h3
  } pic_edge_e;
endpackage : pic_pkg

`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pic_cfg.svh"

module testbench;
  import pic_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pic_addr_t reg_addr = '0;
  logic reg_wr = 1'b0;
  pic_byte_t reg_wdata = '0;
  logic [7:0] rdata, vec, last_vec, calls, base;
  logic req, ack, ret, hsel;
  logic [1:0] preempt;
  logic [14:0] ev = '0;
  logic [3:0] ack_delay = 4'h0;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int lvl;
  // Group register and source slot of each interrupt number
  int mfi_a[16] = '{0, 6, 0, 7, 0, 0, 0, 0, 8, 9, 10, 11, 0, 0, 12, 13};
  int src_i[16] = '{0, 0, 0, 3, 0, 0, 0, 0, 1, 1, 0, 1, 0, 0, 0, 3};

  always #50 clk = ~clk;

  pic_controller pic_controller_i (
    .i_clk(clk), .i_rst_n(rst_n),
    .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
    .i_hall_pin({3{ev[0]}}), .i_ext_irq_pin(ev[11]), .i_filtered_irq_pin(ev[12]),
    .i_comparator_event(ev[1]), .i_pwm_event({ev[2], 3'h0}), .i_pwm_duty3_event(ev[3]),
    .i_capture_overflow_event(ev[4]), .i_capture_compare_event(ev[5]), .i_adc_limit_event(ev[6]),
    .i_adc_eoc_event({ev[7], 1'b0}), .i_timer2_event({ev[8], 1'b0}), .i_timer0_event({1'b0, ev[9]}),
    .i_timer1_event({ev[10], 1'b0}), .i_timer3_event({1'b0, ev[13]}), .i_serial_misc_event({ev[14], 3'h0}),
    .o_irq_req(req), .o_irq_vector(vec), .i_irq_ack(ack), .i_irq_return(ret),
    .o_vector_preempt_ctrl(preempt), .o_hall_source_sel(hsel)
  );

  pic_core_model pic_core_model_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_irq_req(req), .i_irq_vector(vec), .i_ack_delay(ack_delay),
    .o_irq_ack(ack), .o_irq_return(ret), .o_last_vector(last_vec), .o_call_count(calls)
  );

  // ==========================================================
  // Access and check tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input int a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= 5'(a);
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input int a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= 5'(a);
    @(posedge clk);
    #1;
    chk("register", exp, rdata);
  endtask : rd

  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
  endtask : pulse

  // Bounded wait for the core to have taken a given number of calls
  task automatic wait_calls(input logic [7:0] n);
    for (int i = 0; i < 300 && calls !== n; i++) @(posedge clk);
    #1;
    chk("call_count", n, calls);
  endtask : wait_calls

  function automatic logic [7:0] impl(input int a);
    if (a == 0 || a == 2) return 8'h7f;
    if (a == 1) return 8'h0f;
    if (a < 6) return 8'hff;
    if (a < 14) return 8'(`PIC_MFI_IMPL >> (8 * (a - 6)));
    if (a < 22) return 8'(`PIC_MAP_MASK >> (8 * (a - 14)));
    return 8'h00;
  endfunction : impl

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Hang guard, well above the length of the sequence below
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 24; a++) rd(a, 8'h00);
    // Global enable kept off so flag writes cannot start calls here
    for (int a = 0; a < 24; a++) begin
      wr(a, (a == 2) ? 8'hfe : 8'hff);
      rd(a, ((a == 2) ? 8'hfe : 8'hff) & impl(a));
      if (a == 1) chk("preempt", 8'h03, {6'h0, preempt});
      if (a == 0) chk("hall_source_sel", 8'h01, {7'h0, hsel});
      wr(a, 8'h00);
    end
    wr(0, 8'h01);
    wr(1, 8'h01);
    wr(2, 8'h01);
    for (int n = 1; n < 16; n++) begin
      lvl = 16 - n;
      ack_delay <= (n % 2) ? 4'h0 : 4'h6;
      wr(14 + (lvl - 1) / 2, ((lvl - 1) % 2) ? 8'(n << 4) : 8'(n));
      wr(2 + lvl / 4, (lvl < 4) ? 8'(1 | (1 << lvl)) : 8'(1 << (lvl % 4)));
      if (mfi_a[n] != 0) wr(mfi_a[n], 8'h0f);
      base = calls;
      if (n == 1 || n == 12 || n == 13) begin
        @(posedge clk);
        ev[n - 1] <= 1'b1;
      end else begin
        pulse(n - 1);
      end
      wait_calls(base + 8'h01);
      chk("vector", 8'(4 * lvl), last_vec);
      if (mfi_a[n] != 0) rd(mfi_a[n], 8'(8'h0f | (8'h10 << src_i[n])) & impl(mfi_a[n]));
      if (mfi_a[n] != 0) wr(mfi_a[n], 8'h00);
      @(posedge clk);
      ev <= '0;
      repeat (8) @(posedge clk);
    end
    // One number on two levels, held back by the global enable
    wr(14, 8'h22);
    wr(2, 8'h06);
    base = calls;
    pulse(1);
    rd(2, 8'h36);
    chk("call_count", base, calls);
    wr(2, 8'h37);
    wait_calls(base + 8'h01);
    chk("vector", 8'h04, last_vec);
    wait_calls(base + 8'h02);
    chk("vector", 8'h08, last_vec);
    // Unassigned number only raises its source flag
    wr(14, 8'h00);
    wr(17, 8'h00);
    wr(9, 8'h02);
    base = calls;
    pulse(8);
    rd(9, 8'h22);
    rd(3, 8'h01);
    repeat (10) @(posedge clk);
    chk("call_count", base, calls);
    // Falling-edge select on the external pin
    wr(1, 8'h02);
    wr(14, 8'h0c);
    wr(2, 8'h03);
    @(posedge clk);
    ev[11] <= 1'b1;
    repeat (10) @(posedge clk);
    chk("call_count", base, calls);
    ev[11] <= 1'b0;
    wait_calls(base + 8'h01);
    chk("vector", 8'h04, last_vec);
    print_verdict();
  end
endmodule : testbench

`default_nettype wire
